// *** logic/sfi_regs.svh ***
// register offsets, reset values, field masks and timing figures of the sensor front-end config port
`ifndef SFI_REGS_SVH
`define SFI_REGS_SVH

// ----------------------------------------------------------------
// two-wire link
// ----------------------------------------------------------------
`define SFI_SLAVE_ADDR 7'h48
`define SFI_SCL_MAX_HZ 100000
`define SFI_HOLD_NS 300
`define SFI_CLK_HZ 25000000
`define SFI_HZ_PER_MHZ 1000000
`define SFI_NS_PER_US 1000
`define SFI_MS_PER_S 1000

// ----------------------------------------------------------------
// serial register map (pointer values)
// ----------------------------------------------------------------
`define SFI_PTR_STATUS 8'h00
`define SFI_PTR_LOCK 8'h01
`define SFI_PTR_TIACN 8'h10
`define SFI_PTR_REFCN 8'h11
`define SFI_PTR_MODECN 8'h12
`define SFI_STATUS_READY 8'h01
`define SFI_DEF_LOCK 8'h01
`define SFI_DEF_TIACN 8'h03
`define SFI_DEF_REFCN 8'h20
`define SFI_DEF_MODECN 8'h00
`define SFI_MASK_LOCK 8'h01
`define SFI_MASK_TIACN 8'h1C
`define SFI_MASK_REFCN 8'hEF
`define SFI_MASK_MODECN 8'h87
`define SFI_INTZ_BAD 2'h3
`define SFI_GAIN_EXT 3'h0
`define SFI_MODE_SLEEP 3'h0
`define SFI_MODE_3LEAD 3'h3

// ----------------------------------------------------------------
// bus-side registers (byte addresses)
// ----------------------------------------------------------------
`define SFI_AHB_STAT 8'h00
`define SFI_AHB_TOUT 8'h04
`define SFI_AHB_CFG 8'h08
`define SFI_TOUT_DEF_MS 8'h1E
`define SFI_HSIZE_WORD 3'h2

`endif

// *** logic/sfi_pkg.sv ***
// types shared by the sensor front-end config port
package sfi_pkg;

    // two-wire slave sequencer states
    typedef enum logic [2:0] {
        SFI_IDLE,
        SFI_ADDR,
        SFI_PTR,
        SFI_WDATA,
        SFI_ACK,
        SFI_RDATA,
        SFI_RACK,
        SFI_WAIT
    } sfi_state_e;

    // analog settings carried to the front end
    typedef struct packed {
        logic [2:0] tia_gain;
        logic ext_res_sel;
        logic ref_external;
        logic [1:0] int_zero;
        logic [3:0] diag_step;
        logic fet_short;
        logic [2:0] op_mode;
        logic control_amp_on;
        logic tia_on;
        logic load_switch_on;
    } sfi_afe_s;

endpackage : sfi_pkg

// *** logic/sfi_link_guard.sv ***
// pin synchronisers and bus-stuck watchdog of the config port
`timescale 1ns/1ps
`include "sfi_regs.svh"

module sfi_link_guard
    import sfi_pkg::*;
#(
    parameter int CYC_PER_MS = `SFI_CLK_HZ / `SFI_MS_PER_S
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic sel_n_pin,
    input wire logic sda_drive,
    input wire logic [7:0] tout_ms,
    output logic scl_s,
    output logic sda_s,
    output logic module_select_n_s,
    output logic stuck_pulse
);

    logic [1:0] scl_ff_q;
    logic [1:0] sda_ff_q;
    logic [1:0] sel_ff_q;
    logic [15:0] tick_q;
    logic [7:0] ms_q;
    logic stuck_q;
    wire stuck_now;
    wire tick_wrap;
    wire limit_hit;

    // ----------------------------------------------------------------
    // two-flop synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        scl_ff_q <= {scl_ff_q[0], scl_pin}; // R1
        sda_ff_q <= {sda_ff_q[0], sda_pin};
        sel_ff_q <= {sel_ff_q[0], sel_n_pin};
    end

    assign scl_s = scl_ff_q[1];
    assign sda_s = sda_ff_q[1];
    assign module_select_n_s = sel_ff_q[1];

    // ----------------------------------------------------------------
    // stuck-low timer
    // ----------------------------------------------------------------
    // low scl or our own sda drive both count; the count restarts once both are released or the limit is hit
    assign stuck_now = ~scl_ff_q[1] | sda_drive; // R13 R14 R19
    assign tick_wrap = tick_q == 16'(CYC_PER_MS - 1);
    assign limit_hit = stuck_now && (ms_q >= tout_ms); // R19

    // millisecond prescaler and millisecond count
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !stuck_now || limit_hit) begin
            tick_q <= 16'h0000; // R19
            ms_q <= 8'h00;
        end else if (tick_wrap) begin
            tick_q <= 16'h0000;
            ms_q <= ms_q + 8'h01;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end

    // reset request to the serial logic, one cycle long unless the limit is zero, then held while the bus stays stuck
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stuck_q <= 1'b0;
        end else begin
            stuck_q <= limit_hit; // R13 R14
        end
    end

    assign stuck_pulse = stuck_q;

endmodule : sfi_link_guard

// *** logic/sfi_cfg_port.sv ***
// two-wire configuration slave of the sensor front end, with an AHB-Lite status window
//
// How it works
// R1: link runs at standard speed, scl at most 100 kHz, oversampled at 25 MHz.
// R2: fixed seven-bit slave address 1001000, not configurable.
// R3: host keeps module select low for the whole transaction.
// R4: host sends address and direction bit after start, then frees sda.
// R5: matching address is acknowledged; any other address is left unacknowledged.
// R6: in a write the pointer byte follows and is acknowledged by pulling sda low.
// R7: one data byte follows the pointer, is acknowledged and stored.
// R8: host ends a write with stop, then may deselect.
// R9: read is write of pointer, repeated start, then address with read bit.
// R10: after read address acknowledge, the pointed register is shifted out.
// R11: module select may be tied low when the device is alone.
// R12: zero is driven low, one is sent by releasing the open-drain line.
// R13: scl held low past the timeout resets the serial logic.
// R14: our own sda drive held past the timeout resets the logic, releasing sda.
// R15: gain field picks one of seven internal resistors or the external one.
// R16: internal zero picks 67, 50 or 20 percent of supply or reference.
// R17: power saving turns the amplifier off and switches in a matching load.
// R18: control amplifier can be powered down, though host should avoid it.
// R19: timeout counts continuous low time against a programmable millisecond limit.
// R20: register pointer survives the end of a write for later reads.
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "sfi_regs.svh"

module sfi_cfg_port
    import sfi_pkg::*;
#(
    parameter int CYC_PER_MS = `SFI_CLK_HZ / `SFI_MS_PER_S
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic module_select_n,
    output sfi_afe_s afe_ctrl
);

    // hold after a falling scl edge before sda may change, rounded up
    localparam int HOLD_CYC = (`SFI_HOLD_NS * (`SFI_CLK_HZ / `SFI_HZ_PER_MHZ) + `SFI_NS_PER_US - 1) / `SFI_NS_PER_US;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    sfi_state_e state_q;
    sfi_state_e after_ack_q;
    logic scl_s;
    logic sda_s;
    logic sel_n_s;
    logic stuck_pulse;
    logic scl_p_q;
    logic sda_p_q;
    logic [3:0] hold_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic ack_pend_q;
    logic drive_q;
    logic [7:0] lock_q;
    logic [7:0] tiacn_q;
    logic [7:0] refcn_q;
    logic [7:0] modecn_q;
    logic [7:0] tout_q;
    logic [7:0] tout_events_q;
    sfi_afe_s afe_q;
    logic ap_wr_q;
    logic [7:0] ap_addr_q;
    logic [31:0] hrdata_q;

    // ----------------------------------------------------------------
    // pin guard: synchronisers and stuck-bus watchdog
    // ----------------------------------------------------------------
    sfi_link_guard #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_guard (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .scl_pin(scl_in),
        .sda_pin(sda_in),
        .sel_n_pin(module_select_n),
        .sda_drive(drive_q),
        .tout_ms(tout_q),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .module_select_n_s(sel_n_s),
        .stuck_pulse(stuck_pulse)
    );

    // ----------------------------------------------------------------
    // line events
    // ----------------------------------------------------------------
    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire fall_act = hold_q == 4'h1;
    wire last_bit = bit_q == 3'h7;
    wire [7:0] rx_byte = {shift_q[6:0], sda_s};
    // deselect or a stuck bus drops the transfer; settings stay
    wire link_rst = sys_rst | stuck_pulse | sel_n_s; // R3 R13 R14
    wire addr_hit = rx_byte[7:1] == `SFI_SLAVE_ADDR; // R2

    // previous line levels for edge and condition detection
    always_ff @(posedge ref_clk) begin
        scl_p_q <= scl_s;
        sda_p_q <= sda_s;
    end

    // delay from scl fall until sda may move
    always_ff @(posedge ref_clk) begin
        if (link_rst) begin
            hold_q <= 4'h0;
        end else if (scl_fall) begin
            hold_q <= 4'(HOLD_CYC);
        end else if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // register read mux and write qualifiers
    // ----------------------------------------------------------------
    wire [7:0] rd_val =
        (ptr_q == `SFI_PTR_STATUS) ? `SFI_STATUS_READY :
        (ptr_q == `SFI_PTR_LOCK) ? lock_q :
        (ptr_q == `SFI_PTR_TIACN) ? tiacn_q :
        (ptr_q == `SFI_PTR_REFCN) ? refcn_q :
        (ptr_q == `SFI_PTR_MODECN) ? modecn_q : 8'h00; // R10
    wire wr_en = (state_q == SFI_WDATA) & scl_rise & last_bit & ~link_rst; // R7
    wire unlocked = ~lock_q[0];
    wire wr_lock = wr_en & (ptr_q == `SFI_PTR_LOCK);
    wire wr_tia = wr_en & (ptr_q == `SFI_PTR_TIACN) & unlocked;
    wire wr_ref = wr_en & (ptr_q == `SFI_PTR_REFCN) & unlocked;
    wire wr_mode = wr_en & (ptr_q == `SFI_PTR_MODECN);
    // an undefined zero ratio keeps the previous one
    wire [7:0] ref_new = (rx_byte[6:5] == `SFI_INTZ_BAD) ?
        ((rx_byte & `SFI_MASK_REFCN & 8'h9F) | (refcn_q & 8'h60)) : (rx_byte & `SFI_MASK_REFCN); // R16

    // ----------------------------------------------------------------
    // slave sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (link_rst) begin
            state_q <= SFI_IDLE;
            after_ack_q <= SFI_IDLE;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
            ack_pend_q <= 1'b0;
            drive_q <= 1'b0; // R14
        end else if (start_det) begin
            state_q <= SFI_ADDR; // R4 R9
            bit_q <= 3'h0;
            ack_pend_q <= 1'b0;
            drive_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= SFI_IDLE; // R8
            drive_q <= 1'b0;
        end else begin
            unique case (state_q)
                SFI_IDLE, SFI_WAIT: begin
                    drive_q <= 1'b0;
                end
                SFI_ADDR, SFI_PTR, SFI_WDATA: begin
                    if (scl_rise) begin
                        shift_q <= rx_byte;
                        bit_q <= bit_q + 3'h1;
                        if (last_bit) begin
                            if (state_q != SFI_ADDR) begin
                                ack_pend_q <= 1'b1; // R6 R7
                                after_ack_q <= SFI_WDATA;
                            end else if (addr_hit) begin
                                ack_pend_q <= 1'b1; // R5
                                after_ack_q <= rx_byte[0] ? SFI_RDATA : SFI_PTR;
                            end else begin
                                state_q <= SFI_WAIT; // R5
                            end
                        end
                    end else if (fall_act && ack_pend_q) begin
                        ack_pend_q <= 1'b0;
                        drive_q <= 1'b1; // R12
                        state_q <= SFI_ACK;
                    end
                end
                SFI_ACK: begin
                    if (fall_act) begin
                        bit_q <= 3'h0;
                        state_q <= after_ack_q;
                        if (after_ack_q == SFI_RDATA) begin
                            shift_q <= rd_val; // R10
                            drive_q <= ~rd_val[7]; // R12
                        end else begin
                            drive_q <= 1'b0;
                        end
                    end
                end
                SFI_RDATA: begin
                    if (scl_rise) begin
                        bit_q <= bit_q + 3'h1;
                        if (last_bit) begin
                            state_q <= SFI_RACK;
                        end
                    end else if (fall_act) begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        drive_q <= ~shift_q[6]; // R10 R12
                    end
                end
                SFI_RACK: begin
                    if (fall_act) begin
                        drive_q <= 1'b0;
                    end else if (scl_rise) begin
                        // host ack asks for another byte of the same register
                        after_ack_q <= SFI_RDATA;
                        state_q <= sda_s ? SFI_WAIT : SFI_ACK;
                    end
                end
                default: begin
                    state_q <= SFI_IDLE;
                end
            endcase
        end
    end

    // pointer is kept across transactions and timeouts
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ptr_q <= `SFI_PTR_STATUS;
        end else if (state_q == SFI_PTR && scl_rise && last_bit && !link_rst) begin
            ptr_q <= rx_byte; // R6 R20
        end
    end

    // open-drain pad: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = drive_q; // R12

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lock_q <= `SFI_DEF_LOCK;
            tiacn_q <= `SFI_DEF_TIACN;
            refcn_q <= `SFI_DEF_REFCN;
            modecn_q <= `SFI_DEF_MODECN;
        end else begin
            if (wr_lock) begin
                lock_q <= rx_byte & `SFI_MASK_LOCK;
            end
            if (wr_tia) begin
                tiacn_q <= rx_byte & `SFI_MASK_TIACN; // R7 R15
            end
            if (wr_ref) begin
                refcn_q <= ref_new; // R16
            end
            if (wr_mode) begin
                modecn_q <= rx_byte & `SFI_MASK_MODECN; // R17
            end
        end
    end

    // ----------------------------------------------------------------
    // analog control outputs
    // ----------------------------------------------------------------
    wire [2:0] op_mode = modecn_q[2:0];
    wire tia_run = op_mode == `SFI_MODE_3LEAD;

    // registered settings for the front end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            afe_q <= '0;
        end else begin
            afe_q.tia_gain <= tiacn_q[4:2]; // R15
            afe_q.ext_res_sel <= tiacn_q[4:2] == `SFI_GAIN_EXT; // R15
            afe_q.ref_external <= refcn_q[7]; // R16
            afe_q.int_zero <= refcn_q[6:5]; // R16
            afe_q.diag_step <= refcn_q[3:0];
            afe_q.fet_short <= modecn_q[7];
            afe_q.op_mode <= op_mode;
            afe_q.control_amp_on <= op_mode != `SFI_MODE_SLEEP; // R18
            afe_q.tia_on <= tia_run; // R17
            afe_q.load_switch_on <= ~tia_run; // R17
        end
    end

    assign afe_ctrl = afe_q;

    // ----------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ----------------------------------------------------------------
    wire ahb_go = hsel & htrans[1] & hready;
    wire ahb_low = haddr[31:8] == 24'h000000;
    wire [31:0] stat_word = {16'h0000, tout_events_q, 4'h0, 1'b0,
                             ~sel_n_s, state_q != SFI_IDLE, 1'b1};
    wire [31:0] cfg_word = {7'h00, lock_q[0], modecn_q, refcn_q, tiacn_q};
    wire [31:0] ahb_rd =
        !ahb_low ? 32'h00000000 :
        (haddr[7:0] == `SFI_AHB_STAT) ? stat_word :
        (haddr[7:0] == `SFI_AHB_TOUT) ? {24'h000000, tout_q} :
        (haddr[7:0] == `SFI_AHB_CFG) ? cfg_word : 32'h00000000;

    // address phase capture and read data
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
        end else begin
            ap_wr_q <= ahb_go & hwrite & ahb_low & (hsize == `SFI_HSIZE_WORD);
            ap_addr_q <= haddr[7:0];
            hrdata_q <= (ahb_go & ~hwrite) ? ahb_rd : 32'h00000000;
        end
    end

    // timeout limit and timeout event count
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tout_q <= `SFI_TOUT_DEF_MS;
            tout_events_q <= 8'h00;
        end else begin
            if (ap_wr_q && ap_addr_q == `SFI_AHB_TOUT) begin
                tout_q <= hwdata[7:0]; // R19
            end
            if (stuck_pulse) begin
                tout_events_q <= tout_events_q + 8'h01;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

endmodule : sfi_cfg_port

// *** sim/sfi_port_chk_sva.sv ***
// assertion checker for the sensor front-end config port
`timescale 1ns/1ps
module sfi_port_chk
    import sfi_pkg::*;
#(
    parameter int CYC_PER_MS = 25000
) (
    input logic ref_clk,
    input logic sys_rst,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic hready,
    input logic hreadyout,
    input logic hresp,
    input logic [31:0] hrdata,
    input logic scl_in,
    input logic sda_out,
    input logic sda_oe,
    input logic module_select_n,
    input sfi_afe_s afe_ctrl
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ----------------
    // helpers and assertions
    // ----------------
    localparam int STUCK_MAX = 256 * CYC_PER_MS + 16;
    logic [31:0] oe_cnt_q;
    logic [31:0] oe_cnt_d;
    logic rd_take;
    // bus read taken, and run length of our own pull on sda
    assign rd_take = hsel & htrans[1] & hready & !hwrite;
    assign oe_cnt_d = sda_oe ? oe_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge ref_clk) begin
        oe_cnt_q <= sys_rst ? 32'h0 : oe_cnt_d;
    end
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus slave stalled or erred");
    stat_ready_a: assert property (rd_take && haddr == 32'h0 |=> hrdata[0]) else $error("status lacks ready");
    rdata_idle_a: assert property (!rd_take |=> hrdata == 32'h0) else $error("stray read data");
    sda_open_a: assert property (sda_out == 1'b0) else $error("sda driven high");
    oe_on_low_a: assert property ($rose(sda_oe) |-> !scl_in) else $error("sda pulled while scl high");
    oe_steady_a: assert property ((scl_in && oe_cnt_q < 32'h100) [*6] |-> $stable(sda_oe))
        else $error("sda changed during scl high");
    deselect_a: assert property (module_select_n [*8] |-> !sda_oe) else $error("sda pulled while deselected");
    oe_bounded_a: assert property (oe_cnt_q <= STUCK_MAX) else $error("sda held past timeout");
    gain_ext_a: assert property (!$past(sys_rst) |-> afe_ctrl.ext_res_sel == (afe_ctrl.tia_gain == 3'h0))
        else $error("bad external select");
    zero_legal_a: assert property (afe_ctrl.int_zero != 2'h3) else $error("illegal internal zero");
    load_swap_a: assert property (!$past(sys_rst) |-> afe_ctrl.load_switch_on != afe_ctrl.tia_on)
        else $error("load switch not inverse");
    amp_mode_a: assert property (!$past(sys_rst) |-> afe_ctrl.control_amp_on == (afe_ctrl.op_mode != 3'h0))
        else $error("bad amplifier state");
    cover property (rd_take && haddr == 32'h8);
    cover property (oe_cnt_q > 32'h40);
    cover property (afe_ctrl.tia_on && afe_ctrl.ext_res_sel);
endmodule : sfi_port_chk

bind sfi_cfg_port sfi_port_chk #(.CYC_PER_MS(CYC_PER_MS)) chk_u (
    .ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .scl_in, .sda_out, .sda_oe, .module_select_n, .afe_ctrl
);

// *** sim/sfi_host_model.sv ***
// two-wire bus master standing in for the host controller
`timescale 1ns/1ps
module sfi_host_model #(
    parameter int Q_NS = 320
) (
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    // ----------------
    // bus conditions
    // ----------------
    // lines released at power-up, clock stands high outside frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // (repeated) start after the slave's sda hold; odd offset keeps edges off ref_clk
    task automatic start();
        #(Q_NS + 13);
        sda_pull = 1'b0;
        #(2 * Q_NS);
        scl = 1'b1;
        #(Q_NS);
        sda_pull = 1'b1;
        #(Q_NS);
        scl = 1'b0;
    endtask : start
    // one clock: data set in the low phase, line sampled at the rise
    task automatic clk_bit(input logic b, output logic r);
        #(Q_NS);
        sda_pull = !b;
        #(2 * Q_NS);
        scl = 1'b1;
        r = sda_line;
        #(Q_NS);
        scl = 1'b0;
    endtask : clk_bit
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], r);
            rx = {rx[6:0], r};
        end
        clk_bit(last, ack_n);
    endtask : xfer
    // stop: data low, clock high, then data released
    task automatic stop();
        #(Q_NS);
        sda_pull = 1'b1;
        #(Q_NS);
        scl = 1'b1;
        #(Q_NS);
        sda_pull = 1'b0;
        #(Q_NS);
    endtask : stop
endmodule : sfi_host_model

// *** sim/tb_top.sv ***
// self-checking bench of the sensor front-end config port
`timescale 1ns/1ps
module tb_top
    import sfi_pkg::*;
;
    localparam int CPM = 25;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, module_select_n = 1'b1, a;
    logic hreadyout, hresp, sda_out, sda_oe, scl, sda_pull, sda_line, e_lock = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] e_tia = 8'h03, e_ref = 8'h20, e_mode = 8'h00, d;
    logic [7:0] mode_tab [4] = '{8'hFB, 8'h02, 8'h00, 8'h03};
    sfi_afe_s afe_ctrl;
    int failures = 0;
    int total_checks = 0;
    always #20 ref_clk = !ref_clk;
    // open-drain sda with pull-up
    assign sda_line = !(sda_oe && !sda_out) && !sda_pull;
    sfi_cfg_port #(.CYC_PER_MS(CPM)) dut_u (
        .ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .scl_in(scl), .sda_in(sda_line),
        .sda_out, .sda_oe, .module_select_n, .afe_ctrl
    );
    sfi_host_model host_u (.scl, .sda_pull, .sda_line);
    // ----------------
    // tasks
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rv);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, ad};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask : ahb
    task automatic cfg_chk();
        logic [31:0] r;
        ahb(1'b0, 8'h08, 32'h0, r);
        chk(r, {7'h0, e_lock, e_mode, e_ref, e_tia});
        chk(32'(afe_ctrl), {14'h0, e_tia[4:2], e_tia[4:2] == 3'h0, e_ref[7], e_ref[6:5], e_ref[3:0], e_mode[7],
            e_mode[2:0], e_mode[2:0] != 3'h0, e_mode[2:0] == 3'h3, e_mode[2:0] != 3'h3});
    endtask : cfg_chk
    task automatic probe(input logic [7:0] ab, input logic exp_n);
        logic [7:0] x;
        logic n;
        host_u.start();
        host_u.xfer(ab, 1'b1, x, n);
        host_u.stop();
        chk(32'(n), 32'(exp_n));
    endtask : probe
    task automatic wr_reg(input logic [7:0] p, input logic [7:0] v);
        logic [7:0] x;
        logic a0, a1, a2;
        host_u.start();
        host_u.xfer(8'h90, 1'b1, x, a0);
        host_u.xfer(p, 1'b1, x, a1);
        host_u.xfer(v, 1'b1, x, a2);
        host_u.stop();
        chk({29'h0, a0, a1, a2}, 32'h0);
    endtask : wr_reg
    task automatic rd_reg(input logic setp, input logic [7:0] p, input logic [7:0] exp);
        logic [7:0] x;
        logic a0 = 1'b0, a1 = 1'b0, a2, n;
        host_u.start();
        if (setp) begin
            host_u.xfer(8'h90, 1'b1, x, a0);
            host_u.xfer(p, 1'b1, x, a1);
            host_u.start();
        end
        host_u.xfer(8'h91, 1'b1, x, a2);
        host_u.xfer(8'hFF, 1'b1, x, n);
        host_u.stop();
        chk({21'h0, a0, a1, a2, x}, {24'h0, exp});
    endtask : rd_reg
    task automatic wait_oe(input logic v);
        for (int n = 0; n < 400 && sda_oe !== v; n++) begin
            @(posedge ref_clk);
        end
        chk(32'(sda_oe), 32'(v));
    endtask : wait_oe
    // ----------------
    // tests
    // ----------------
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        cfg_chk();
        ahb(1'b0, 8'h04, 32'h0, rd);
        chk(rd, 32'h1E);
        ahb(1'b0, 8'h0C, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test reset done");
        probe(8'h90, 1'b1);
        @(posedge ref_clk);
        module_select_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        for (int i = 1; i < 8; i++) begin
            probe(8'h90 ^ (8'h01 << i), 1'b1);
        end
        probe(8'h90, 1'b0);
        $display("test address done");
        wr_reg(8'h10, 8'h14);
        cfg_chk();
        wr_reg(8'h01, 8'h00);
        e_lock = 1'b0;
        for (int g = 0; g < 8; g++) begin
            wr_reg(8'h10, {3'h0, 3'(g), 2'h0});
            e_tia = {3'h0, 3'(g), 2'h0};
            cfg_chk();
        end
        for (int z = 0; z < 4; z++) begin
            wr_reg(8'h11, {z[0], z[1:0], 1'b0, 4'h5});
            e_ref = {z[0], (z < 3) ? z[1:0] : e_ref[6:5], 1'b0, 4'h5};
            cfg_chk();
        end
        foreach (mode_tab[k]) begin
            wr_reg(8'h12, mode_tab[k]);
            e_mode = mode_tab[k] & 8'h87;
            cfg_chk();
        end
        $display("test write done");
        rd_reg(1'b1, 8'h12, 8'h03);
        rd_reg(1'b0, 8'h00, 8'h03);
        rd_reg(1'b1, 8'h11, e_ref);
        rd_reg(1'b1, 8'h00, 8'h01);
        rd_reg(1'b1, 8'h05, 8'h00);
        $display("test read done");
        ahb(1'b1, 8'h04, 32'h3, rd);
        host_u.start();
        host_u.xfer(8'h91, 1'b1, d, a);
        wait_oe(1'b1);
        wait_oe(1'b0);
        host_u.stop();
        ahb(1'b0, 8'h00, 32'h0, rd);
        chk(rd, 32'h105);
        wr_reg(8'h12, 8'h02);
        e_mode = 8'h02;
        cfg_chk();
        $display("test timeout done");
        test_done();
    end
    // some thirty-four frames of at most about 51 us; 3 ms means a hang
    initial begin
        #3_000_000;
        failures++;
        test_done();
    end
endmodule : tb_top
